// file: hdl/snf_consts.vh
// snf_consts.vh: constants of the serial feature-register front end
// assumes inclusion by bare name from the design files
`ifndef SNF_CONSTS_VH
`define SNF_CONSTS_VH
// -----------------------------------------------------------------
// opcodes
// -----------------------------------------------------------------
`define SNF_OP_GET_FEATURE 8'h0f
`define SNF_OP_SET_FEATURE 8'h1f
`define SNF_OP_WRITE_ENABLE 8'h06
`define SNF_OP_WRITE_DISABLE 8'h04
`define SNF_OP_RESET 8'hff
`define SNF_OP_PROGRAM_EXECUTE 8'h10
`define SNF_OP_PAGE_READ 8'h13
`define SNF_OP_BLOCK_ERASE 8'hd8
// -----------------------------------------------------------------
// feature addresses and reset values
// -----------------------------------------------------------------
`define SNF_ADDR_PROTECT 8'ha0
`define SNF_ADDR_OTP 8'hb0
`define SNF_ADDR_STATUS 8'hc0
`define SNF_ADDR_DRIVE 8'hd0
`define SNF_RST_PROTECT 8'h38
`define SNF_RST_OTP 8'h10
`define SNF_RST_DRIVE 8'h20
// writable bit masks; reserved bits read zero
`define SNF_MASK_PROTECT 8'hb8
`define SNF_MASK_OTP 8'hd0
`define SNF_MASK_DRIVE 8'h60
// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define SNF_BIT_LOCK_WD 7
`define SNF_BIT_RANGE_HI 5
`define SNF_BIT_RANGE_LO 3
`define SNF_BIT_OTP_PROT 7
`define SNF_BIT_OTP_EN 6
`define SNF_BIT_ECC_EN 4
`define SNF_BIT_DRV_HI 6
`define SNF_BIT_DRV_LO 5
`define SNF_BIT_ECCS_HI 5
`define SNF_BIT_ECCS_LO 4
`define SNF_BIT_PFAIL 3
`define SNF_BIT_EFAIL 2
`define SNF_BIT_WEL 1
`define SNF_BIT_BUSY 0
// -----------------------------------------------------------------
// timing, clock 250 MHz
// -----------------------------------------------------------------
// sized to the timer width so no cycle count is cut silently
`define SNF_CLK_MHZ 24'hfa
`define SNF_PAGE_LOAD_US 24'h64
`define SNF_PROGRAM_US 24'h384
`define SNF_ERASE_US 24'h2710
`define SNF_RST_IDLE_US 24'h5
`define SNF_RST_READ_US 24'h64
`define SNF_RST_PROG_US 24'h384
`define SNF_RST_ERASE_US 24'h1f4
`define SNF_RST_FIRST_US 24'h3e8
// no time rounds: us times MHz is exact
`define SNF_CYC(us) ((us) * `SNF_CLK_MHZ)
`endif

// file: hdl/snf_busy_timer.v
// snf_busy_timer.v: down-counter that holds busy for a loaded cycle count
// assumes the load pulse and count come from the same clock domain
`timescale 1ns/1ps
module snf_busy_timer #(
  parameter WIDTH = 24
) (
  input wire clock,
  input wire nrst,
  input wire load,
  input wire [WIDTH-1:0] cycles,
  output reg busy,
  output reg done
);
  reg [WIDTH-1:0] count_q;
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      count_q <= {WIDTH{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (load)
      begin
        count_q <= cycles;
        busy <= 1'b1;
      end
      else if (busy)
      begin
        if (count_q <= {{(WIDTH-1){1'b0}}, 1'b1})
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// file: hdl/snf_feature_regs.v
// snf_feature_regs.v: serial front end with feature registers and write latch
// assumes sck, csN, si arrive asynchronously; clock well above 4x sck
//
// What this block and its host do
// R1: works in clock mode 0 and mode 3
// R2: sample on rising sck, shift on falling
// R3: host idles sck while deselected
// R4: host keeps deselect gaps, sck limit
// R5: get/set feature take one address byte
// R6: feature values survive reset command
// R7: protect range code selects locked array fraction
// R8: block lock powers up at 38h
// R9: lock write-disable bit stays writable
// R10: otp bit4 enables ecc, reset 10h
// R11: otp bits 7..6 select otp state
// R12: status readable while busy
// R13: status field layout busy wel fails ecc
// R14: write latch clear after power-up
// R15: drive register 20h, bits 6..5 strength
// R16: 06h sets write latch
// R17: 04h clears write latch, blocks writes
// R18: busy for load, program, erase times
// R19: host limits partial programs per page
// R20: reset busy time by state, first longer
// R21: busy flag tracks running operations
// R22: ecc status codes
// R23: program fail set/cleared
// R24: erase fail set/cleared
// R25: reserved bits zero, status not writable
`timescale 1ns/1ps
`include "snf_consts.vh"
module snf_feature_regs #(
  parameter TW = 24,
  parameter [TW-1:0] PAGE_LOAD_CYC = `SNF_CYC(`SNF_PAGE_LOAD_US),
  parameter [TW-1:0] PROGRAM_CYC = `SNF_CYC(`SNF_PROGRAM_US),
  parameter [TW-1:0] ERASE_CYC = `SNF_CYC(`SNF_ERASE_US),
  parameter [TW-1:0] RST_IDLE_CYC = `SNF_CYC(`SNF_RST_IDLE_US),
  parameter [TW-1:0] RST_READ_CYC = `SNF_CYC(`SNF_RST_READ_US),
  parameter [TW-1:0] RST_PROG_CYC = `SNF_CYC(`SNF_RST_PROG_US),
  parameter [TW-1:0] RST_ERASE_CYC = `SNF_CYC(`SNF_RST_ERASE_US),
  parameter [TW-1:0] RST_FIRST_CYC = `SNF_CYC(`SNF_RST_FIRST_US)
) (
  input wire clock,
  input wire nrst,
  input wire sck,
  input wire csN,
  input wire si,
  output reg so,
  output reg soOeN,
  input wire wpN,
  input wire arrayFail,
  input wire [1:0] eccResult,
  output reg [2:0] protectRange,
  output reg lockRegWriteDisable,
  output reg eccEnable,
  output reg [1:0] otpState,
  output reg [1:0] driveStrength,
  output reg busyFlag,
  output reg writeEnableLatch
);
  // -----------------------------------------------------------------
  // synchronisers
  // -----------------------------------------------------------------
  reg [1:0] sckMeta_q;
  reg [1:0] csMeta_q;
  reg [1:0] siMeta_q;
  reg [1:0] wpMeta_q;
  reg sckPrev_q;
  wire sckS = sckMeta_q[1];
  wire csS = csMeta_q[1];
  wire siS = siMeta_q[1];
  wire wpS = wpMeta_q[1];
  // R1 R2: edges are found from sck level alone, so polarity at idle is free
  wire sckRise = sckS & ~sckPrev_q & ~csS;
  wire sckFall = ~sckS & sckPrev_q & ~csS;
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sckMeta_q <= 2'h0;
      csMeta_q <= 2'h3;
      siMeta_q <= 2'h0;
      wpMeta_q <= 2'h3;
      sckPrev_q <= 1'b0;
    end
    else
    begin
      sckMeta_q <= {sckMeta_q[0], sck};
      csMeta_q <= {csMeta_q[0], csN};
      siMeta_q <= {siMeta_q[0], si};
      wpMeta_q <= {wpMeta_q[0], wpN};
      sckPrev_q <= sckS;
    end
  end

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  localparam [3:0] ST_OP = 4'h1;
  localparam [3:0] ST_ADDR = 4'h2;
  localparam [3:0] ST_DATA = 4'h4;
  localparam [3:0] ST_SKIP = 4'h8;
  localparam [1:0] OPK_NONE = 2'h0;
  localparam [1:0] OPK_READ = 2'h1;
  localparam [1:0] OPK_PROG = 2'h2;
  localparam [1:0] OPK_ERASE = 2'h3;

  reg [3:0] state_q;
  reg [7:0] shift_q;
  reg [2:0] bitCnt_q;
  reg [7:0] opcode_q;
  reg [7:0] featAddr_q;
  reg [7:0] outShift_q;
  reg [7:0] protect_q;
  reg [7:0] otp_q;
  reg [7:0] drive_q;
  reg [1:0] eccStat_q;
  reg progFail_q;
  reg eraseFail_q;
  reg wel_q;
  reg [1:0] opKind_q;
  reg resetting_q;
  reg firstReset_q;
  reg timerLoad_q;
  reg [TW-1:0] timerCycles_q;
  wire timerBusy;
  wire timerDone;

  snf_busy_timer #(.WIDTH(TW)) uTimer (
    .clock(clock),
    .nrst(nrst),
    .load(timerLoad_q),
    .cycles(timerCycles_q),
    .busy(timerBusy),
    .done(timerDone)
  );

  // busy also covers the load cycle so no gap shows
  wire busyNow = timerBusy | timerLoad_q; // R21

  wire [7:0] statusByte = {2'h0, eccStat_q, progFail_q, eraseFail_q,
    wel_q, busyNow}; // R13 R25

  function [7:0] read_feature;
    input [7:0] addr;
    begin
      case (addr)
        `SNF_ADDR_PROTECT: read_feature = protect_q;
        `SNF_ADDR_OTP: read_feature = otp_q;
        `SNF_ADDR_STATUS: read_feature = statusByte; // R12
        `SNF_ADDR_DRIVE: read_feature = drive_q;
        default: read_feature = 8'h00;
      endcase
    end
  endfunction

  function [TW-1:0] reset_time;
    input first;
    input [1:0] kind;
    input running;
    begin
      if (first)
        reset_time = RST_FIRST_CYC;
      else if (!running)
        reset_time = RST_IDLE_CYC;
      else
      begin
        case (kind)
          OPK_READ: reset_time = RST_READ_CYC;
          OPK_PROG: reset_time = RST_PROG_CYC;
          OPK_ERASE: reset_time = RST_ERASE_CYC;
          default: reset_time = RST_IDLE_CYC;
        endcase
      end
    end
  endfunction

  wire [7:0] byteIn = {shift_q[6:0], siS};
  wire byteDone = sckRise & (bitCnt_q == 3'h7);
  // locked when protect range covers everything; finer ranges need row address
  wire fullyLocked = (protect_q[`SNF_BIT_RANGE_HI:`SNF_BIT_RANGE_LO] == 3'h7);

  // -----------------------------------------------------------------
  // command engine
  // -----------------------------------------------------------------
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= ST_OP;
      shift_q <= 8'h00;
      bitCnt_q <= 3'h0;
      opcode_q <= 8'h00;
      featAddr_q <= 8'h00;
      outShift_q <= 8'h00;
      protect_q <= `SNF_RST_PROTECT; // R8
      otp_q <= `SNF_RST_OTP; // R10
      drive_q <= `SNF_RST_DRIVE; // R15
      eccStat_q <= 2'h0;
      progFail_q <= 1'b0;
      eraseFail_q <= 1'b0;
      wel_q <= 1'b0; // R14
      opKind_q <= OPK_NONE;
      resetting_q <= 1'b0;
      firstReset_q <= 1'b1;
      timerLoad_q <= 1'b0;
      timerCycles_q <= {TW{1'b0}};
    end
    else
    begin
      timerLoad_q <= 1'b0;
      if (timerDone)
      begin
        if (opKind_q == OPK_READ && !resetting_q)
          eccStat_q <= otp_q[`SNF_BIT_ECC_EN] ? eccResult : 2'h0; // R22
        if (opKind_q == OPK_PROG && arrayFail)
          progFail_q <= 1'b1; // R23
        if (opKind_q == OPK_ERASE && arrayFail)
          eraseFail_q <= 1'b1; // R24
        if (opKind_q == OPK_PROG || opKind_q == OPK_ERASE)
          wel_q <= 1'b0;
        opKind_q <= OPK_NONE;
        resetting_q <= 1'b0;
      end
      if (csS)
      begin
        // deselect ends any command; partial bytes are dropped
        state_q <= ST_OP;
        bitCnt_q <= 3'h0;
      end
      else
      begin
        if (sckRise)
        begin
          shift_q <= byteIn; // R2
          bitCnt_q <= bitCnt_q + 3'h1;
        end
        if (sckFall)
          outShift_q <= {outShift_q[6:0], 1'b0}; // R2
        if (byteDone)
        begin
          case (state_q)
            ST_OP:
            begin
              opcode_q <= byteIn;
              state_q <= ST_SKIP;
              case (byteIn)
                `SNF_OP_GET_FEATURE, `SNF_OP_SET_FEATURE: state_q <= ST_ADDR; // R5
                `SNF_OP_WRITE_ENABLE: wel_q <= 1'b1; // R16
                `SNF_OP_WRITE_DISABLE: wel_q <= 1'b0; // R17
                `SNF_OP_RESET:
                begin
                  // feature registers keep their values
                  timerCycles_q <= reset_time(firstReset_q, opKind_q, busyNow); // R20 R6
                  timerLoad_q <= 1'b1;
                  firstReset_q <= 1'b0;
                  resetting_q <= 1'b1;
                  // an aborted program or erase must not flag a fail afterwards
                  opKind_q <= OPK_NONE; // R23 R24
                  eccStat_q <= 2'h0;
                  progFail_q <= 1'b0; // R23
                  eraseFail_q <= 1'b0; // R24
                  wel_q <= 1'b0;
                end
                `SNF_OP_PAGE_READ:
                  if (!busyNow)
                  begin
                    timerCycles_q <= PAGE_LOAD_CYC; // R18
                    timerLoad_q <= 1'b1;
                    opKind_q <= OPK_READ;
                    eccStat_q <= 2'h0;
                  end
                `SNF_OP_PROGRAM_EXECUTE:
                  if (!busyNow)
                  begin
                    progFail_q <= 1'b0; // R23
                    if (!wel_q || fullyLocked)
                      progFail_q <= wel_q; // R17 R23
                    else
                    begin
                      timerCycles_q <= PROGRAM_CYC; // R18
                      timerLoad_q <= 1'b1;
                      opKind_q <= OPK_PROG;
                    end
                  end
                `SNF_OP_BLOCK_ERASE:
                  if (!busyNow)
                  begin
                    eraseFail_q <= 1'b0; // R24
                    if (!wel_q || fullyLocked)
                      eraseFail_q <= wel_q; // R17 R24
                    else
                    begin
                      timerCycles_q <= ERASE_CYC; // R18
                      timerLoad_q <= 1'b1;
                      opKind_q <= OPK_ERASE;
                    end
                  end
                default: state_q <= ST_SKIP;
              endcase
            end
            ST_ADDR:
            begin
              featAddr_q <= byteIn; // R5
              state_q <= ST_DATA;
              if (opcode_q == `SNF_OP_GET_FEATURE)
                outShift_q <= read_feature(byteIn); // R12
            end
            ST_DATA:
            begin
              state_q <= ST_SKIP;
              if (opcode_q == `SNF_OP_SET_FEATURE)
              begin
                case (featAddr_q)
                  `SNF_ADDR_PROTECT:
                  begin
                    // R9: write-disable bit itself always writable
                    if (protect_q[`SNF_BIT_LOCK_WD] && !wpS)
                      protect_q[`SNF_BIT_LOCK_WD] <= byteIn[`SNF_BIT_LOCK_WD];
                    else
                      protect_q <= byteIn & `SNF_MASK_PROTECT; // R7 R25
                  end
                  `SNF_ADDR_OTP: otp_q <= byteIn & `SNF_MASK_OTP; // R10 R11 R25
                  `SNF_ADDR_DRIVE: drive_q <= byteIn & `SNF_MASK_DRIVE; // R15 R25
                  default: state_q <= ST_SKIP; // R25: status ignores writes
                endcase
              end
            end
            default: state_q <= ST_SKIP;
          endcase
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      so <= 1'b0;
      soOeN <= 1'b1;
      protectRange <= 3'h7;
      lockRegWriteDisable <= 1'b0;
      eccEnable <= 1'b1;
      otpState <= 2'h0;
      driveStrength <= 2'h1;
      busyFlag <= 1'b0;
      writeEnableLatch <= 1'b0;
    end
    else
    begin
      // drive only from the get-feature data phase until deselect
      // keeps driving past the data byte so its last bit is not cut
      soOeN <= ~(~csS && (state_q == ST_DATA || state_q == ST_SKIP) &&
        opcode_q == `SNF_OP_GET_FEATURE);
      // first fall after the address presents bit 7, later falls the rest
      if (sckFall)
        so <= outShift_q[7]; // R2
      protectRange <= protect_q[`SNF_BIT_RANGE_HI:`SNF_BIT_RANGE_LO]; // R7
      lockRegWriteDisable <= protect_q[`SNF_BIT_LOCK_WD];
      eccEnable <= otp_q[`SNF_BIT_ECC_EN]; // R10
      otpState <= otp_q[`SNF_BIT_OTP_PROT:`SNF_BIT_OTP_EN]; // R11
      driveStrength <= drive_q[`SNF_BIT_DRV_HI:`SNF_BIT_DRV_LO]; // R15
      busyFlag <= busyNow; // R21
      writeEnableLatch <= wel_q;
    end
  end
endmodule

// file: bench/snf_feature_regs_monitor.sv
// snf_feature_regs_monitor.sv: port checks of the serial feature front end
// assumes a bind onto snf_feature_regs, one clock domain
`timescale 1ns/1ps
module snf_feature_regs_monitor #(
  parameter int BUSY_MAX = 1000
) (
  input wire clock,
  input wire nrst,
  input wire sck,
  input wire csN,
  input wire si,
  input wire so,
  input wire soOeN,
  input wire wpN,
  input wire arrayFail,
  input wire [1:0] eccResult,
  input wire [2:0] protectRange,
  input wire lockRegWriteDisable,
  input wire eccEnable,
  input wire [1:0] otpState,
  input wire [1:0] driveStrength,
  input wire busyFlag,
  input wire writeEnableLatch
);
  // ----
  // checks
  // ----
  wire [6:0] feat = {protectRange, lockRegWriteDisable, eccEnable, otpState};
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // eight idle clocks outlast the input synchronisers
  sequence deselected;
    csN [*8];
  endsequence
  sequence released;
    $rose(nrst);
  endsequence
  a_oe_idle: assert property (deselected |-> soOeN)
    else $error("so driven while deselected");
  a_oe_start: assert property ($fell(soOeN) |-> !csN)
    else $error("so enabled without select");
  a_so_edge: assert property (!soOeN && !$past(soOeN, 2) && $changed(so) |-> !sck)
    else $error("so changed with sck high");
  a_feat_stable: assert property (deselected |=> $stable(feat) && $stable(driveStrength))
    else $error("feature changed while idle");
  a_wel_quiet: assert property (deselected |=> !$rose(writeEnableLatch))
    else $error("latch set while idle");
  a_busy_bound: assert property ($rose(busyFlag) |-> ##[1:BUSY_MAX] !busyFlag)
    else $error("busy too long");
  a_lock_reset: assert property (released |-> protectRange == 3'h7 && !lockRegWriteDisable)
    else $error("lock reset value");
  a_otp_reset: assert property (released |-> eccEnable && otpState == 2'h0)
    else $error("otp reset value");
  a_drive_reset: assert property (released |-> driveStrength == 2'h1)
    else $error("drive reset value");
  a_wel_reset: assert property (released |-> !writeEnableLatch && !busyFlag)
    else $error("status reset value");
endmodule

// file: bench/snf_host_model.sv
// snf_host_model.sv: host controller model on the serial pins
// assumes a 4 ns clock; the bench calls frame
`timescale 1ns/1ps
module snf_host_model (
  input wire clock,
  output logic sck,
  output logic csN,
  output logic si,
  input wire so
);
  // ----
  // frames
  // ----
  logic mode3 = 1'b0;
  initial
  begin
    sck = 1'b0;
    csN = 1'b1;
    si = 1'b1;
  end
  // six clocks a half: 48 ns link period
  task automatic half();
    repeat (6) @(negedge clock);
  endtask
  task automatic frame(input logic [31:0] w, input int nb, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    sck = mode3;
    half();
    csN = 1'b0;
    half();
    for (i = 0; i < nb * 8; i++)
    begin
      sck = 1'b0;
      si = w[31 - i];
      half();
      sck = 1'b1;
      half();
      rd = {rd[6:0], so};
    end
    sck = mode3;
    half();
    csN = 1'b1;
    // released line must not look held
    si = ~si;
    repeat (30) @(negedge clock);
  endtask
endmodule

// file: bench/tb_top.sv
// tb_top.sv: self-checking bench of the serial feature front end
// assumes the host model drives sck, csN and si
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    checks++; \
    if ((a) !== (e)) \
    begin \
      err_count++; \
      $display("ERROR t=%0t got %h exp %h", $time, a, e); \
    end \
  end
module tb_top;
  logic clock, nrst, sck, csN, si, so, soOeN, wpN, arrayFail;
  logic [1:0] eccResult, otpState, driveStrength;
  logic [2:0] protectRange;
  logic lockRegWriteDisable, eccEnable, busyFlag, writeEnableLatch;
  logic [7:0] r;
  // released so line floats high, as a pull-up would hold it
  logic soPin;
  assign soPin = soOeN ? 1'b1 : so;
  int err_count, checks, cyc, i;
  // ----
  // design and host
  // ----
  // short busy times keep the run small
  snf_feature_regs #(.PAGE_LOAD_CYC(24'd600), .PROGRAM_CYC(24'd700), .ERASE_CYC(24'd800),
    .RST_IDLE_CYC(24'd400), .RST_FIRST_CYC(24'd900)) dut (
    .clock(clock), .nrst(nrst), .sck(sck), .csN(csN), .si(si), .so(so), .soOeN(soOeN),
    .wpN(wpN), .arrayFail(arrayFail), .eccResult(eccResult), .protectRange(protectRange),
    .lockRegWriteDisable(lockRegWriteDisable), .eccEnable(eccEnable), .otpState(otpState),
    .driveStrength(driveStrength), .busyFlag(busyFlag), .writeEnableLatch(writeEnableLatch));
  snf_host_model host (.clock(clock), .sck(sck), .csN(csN), .si(si), .so(soPin));
  always #2 clock = ~clock;
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_count++;
      end_sim();
    end
  end
  // ----
  // tasks
  // ----
  task automatic cmd(input logic [31:0] w, input int nb);
    host.frame(w, nb, r);
  endtask
  task automatic setf(input logic [7:0] a, input logic [7:0] d);
    cmd({8'h1f, a, d, 8'h00}, 3);
  endtask
  task automatic getf(input logic [7:0] a);
    cmd({8'h0f, a, 16'h0000}, 3);
  endtask
  task automatic waitb();
    int n;
    n = 0;
    while (busyFlag !== 1'b0 && n < 1500)
    begin
      @(negedge clock);
      n++;
    end
    `CHK(busyFlag, 1'b0)
  endtask
  task automatic end_sim();
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial
  begin
    clock = 1'b0;
    nrst = 1'b0;
    wpN = 1'b1;
    arrayFail = 1'b0;
    eccResult = 2'h0;
    repeat (10) @(negedge clock);
    nrst = 1'b1;
    getf(8'ha0);
    `CHK(r, 8'h38)
    getf(8'hb0);
    `CHK(r, 8'h10)
    getf(8'hd0);
    `CHK(r, 8'h20)
    getf(8'hc0);
    `CHK(r, 8'h00)
    setf(8'hc0, 8'hff);
    getf(8'hc0);
    `CHK(r, 8'h00)
    for (i = 0; i < 8; i++)
    begin
      host.mode3 = i[0];
      setf(8'ha0, {2'b11, i[2:0], 3'h7});
      `CHK(protectRange, i[2:0])
      getf(8'ha0);
      `CHK(r, {2'b10, i[2:0], 3'h0})
    end
    for (i = 0; i < 4; i++)
    begin
      setf(8'hd0, {1'b1, i[1:0], 5'h1f});
      `CHK(driveStrength, i[1:0])
      getf(8'hd0);
      `CHK(r, {1'b0, i[1:0], 5'h00})
    end
    host.mode3 = 1'b0;
    setf(8'ha0, 8'h80);
    wpN = 1'b0;
    setf(8'ha0, 8'h38);
    getf(8'ha0);
    `CHK(r, 8'h00)
    setf(8'ha0, 8'h38);
    getf(8'ha0);
    `CHK(r, 8'h38)
    wpN = 1'b1;
    cmd(32'h06000000, 1);
    `CHK(writeEnableLatch, 1'b1)
    getf(8'hc0);
    `CHK(r, 8'h02)
    cmd(32'h04000000, 1);
    cmd(32'h10000000, 4);
    getf(8'hc0);
    `CHK(r, 8'h00)
    cmd(32'h06000000, 1);
    cmd(32'h10000000, 4);
    waitb();
    getf(8'hc0);
    `CHK(r & 8'h0c, 8'h08)
    cmd(32'h06000000, 1);
    cmd(32'hd8000000, 4);
    waitb();
    getf(8'hc0);
    `CHK(r & 8'h0c, 8'h0c)
    setf(8'ha0, 8'h00);
    arrayFail = 1'b1;
    cmd(32'h06000000, 1);
    cmd(32'hd8000000, 4);
    waitb();
    arrayFail = 1'b0;
    getf(8'hc0);
    `CHK(r, 8'h0c)
    cmd(32'h06000000, 1);
    cmd(32'h10000000, 4);
    waitb();
    getf(8'hc0);
    `CHK(r, 8'h04)
    setf(8'ha0, 8'h28);
    cmd(32'hff000000, 1);
    `CHK(busyFlag, 1'b1)
    repeat (500) @(negedge clock);
    `CHK(busyFlag, 1'b1)
    waitb();
    getf(8'hc0);
    `CHK(r, 8'h00)
    getf(8'ha0);
    `CHK(r, 8'h28)
    cmd(32'hff000000, 1);
    repeat (500) @(negedge clock);
    `CHK(busyFlag, 1'b0)
    for (i = 0; i < 3; i++)
    begin
      eccResult = i[1:0];
      cmd(32'h13000000, 4);
      getf(8'hc0);
      `CHK(r, 8'h01)
      waitb();
      getf(8'hc0);
      `CHK(r, {2'b00, i[1:0], 4'h0})
    end
    // the locking state comes last: it may freeze the register
    for (i = 0; i < 4; i++)
    begin
      setf(8'hb0, {i[1:0], 1'b1, i[0], 4'hf});
      `CHK(otpState, i[1:0])
      `CHK(eccEnable, i[0])
      getf(8'hb0);
      `CHK(r, {i[1:0], 1'b0, i[0], 4'h0})
    end
    end_sim();
  end
endmodule
bind snf_feature_regs snf_feature_regs_monitor mon (
  .clock(clock), .nrst(nrst), .sck(sck), .csN(csN), .si(si), .so(so), .soOeN(soOeN),
  .wpN(wpN), .arrayFail(arrayFail), .eccResult(eccResult), .protectRange(protectRange),
  .lockRegWriteDisable(lockRegWriteDisable), .eccEnable(eccEnable), .otpState(otpState),
  .driveStrength(driveStrength), .busyFlag(busyFlag), .writeEnableLatch(writeEnableLatch));
